// ===== design/rbctl_regs.vh
`ifndef RBCTL_REGS_VH
`define RBCTL_REGS_VH
`define RBCTL_ADDR 8'h70
`define RBCTL_RESET 8'h00
`define RBCTL_MODE_RESET 2'h0
`define RBCTL_RTR_RESET 1'b0
`define RBCTL_HIT_RESET 3'h0
`define RBCTL_MODE_HI 6
`define RBCTL_MODE_LO 5
`define RBCTL_RTR_BIT 3
`define RBCTL_HIT_HI 2
`define RBCTL_HIT_LO 0
`define RBCTL_MODE_ANY 2'h3
`define RBCTL_MODE_EXT 2'h2
`define RBCTL_MODE_STD 2'h1
`define RBCTL_MODE_ALL 2'h0
`define RBCTL_HIT_F0 3'h0
`define RBCTL_HIT_F1 3'h1
`define RBCTL_HIT_F4 3'h4
`define RBCTL_HIT_F5 3'h5
`endif

// ===== design/rbctl_buffer_one_control.v
`timescale 1ns/1ps
`include "rbctl_regs.vh"
module rbctl_buffer_one_control
(
    input wire clk,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire msg_valid,
    input wire msg_extended,
    input wire msg_remote,
    input wire msg_filter_hit,
    input wire [2:0] msg_filter_index,
    input wire rollover_enable,
    input wire buffer_zero_full,
    input wire buffer_one_free,
    output reg load_buffer_one,
    output reg load_rollover
);
    // Field widths of the register.
    localparam MODE_W = 2;
    localparam HIT_W = 3;

    // Stored fields of the register and their next values.
    reg [MODE_W-1:0] mode_r;
    reg [MODE_W-1:0] mode_nxt;
    reg rtr_r;
    reg rtr_nxt;
    reg [HIT_W-1:0] hit_r;
    reg [HIT_W-1:0] hit_nxt;

    // Next values of the registered outputs.
    reg [7:0] rdata_nxt;
    reg load_one_nxt;
    reg load_roll_nxt;

    // Decisions about the message offered in this cycle.
    reg accept;
    reg from_zero;
    reg roll_ok;
    reg route_one;

    // Register bus decode and the assembled read value.
    wire sel;
    wire wr_hit;
    wire [7:0] status;

    // Tells whether the mode field lets a message in.
    // Buffer space and rollover are judged separately.
    function mode_accepts;
        input [1:0] mode;
        input valid;
        input hit;
        input ext;
        begin
            case (mode)
                `RBCTL_MODE_ANY:
                begin
                    mode_accepts = valid;
                end
                `RBCTL_MODE_EXT:
                begin
                    mode_accepts = valid & hit & ext;
                end
                `RBCTL_MODE_STD:
                begin
                    mode_accepts = valid & hit & ~ext;
                end
                default:
                begin
                    mode_accepts = valid & hit;
                end
            endcase
        end
    endfunction

    // Tells whether a filter index belongs to the first buffer's filters.
    // Such a message can only reach this buffer by rollover.
    function is_zero_filter;
        input [2:0] index;
        begin
            is_zero_filter = (index == `RBCTL_HIT_F0) ||
                             (index == `RBCTL_HIT_F1);
        end
    endfunction

    assign sel = (reg_addr == `RBCTL_ADDR);

    // A write only counts when it is aimed at this register.
    assign wr_hit = reg_wr & sel;

    assign status = {1'b0, mode_r, 1'b0, rtr_r, hit_r};

    always @*
    begin
        accept = mode_accepts(mode_r, msg_valid, msg_filter_hit,
                              msg_extended);

        from_zero = is_zero_filter(msg_filter_index);

        roll_ok = rollover_enable & buffer_zero_full;

        // filters 0 and 1 only by rollover.
        if (from_zero)
        begin
            route_one = accept & roll_ok;
        end
        else
        begin
            route_one = accept;
        end

        // A full buffer drops the message rather than overwriting it.
        route_one = route_one & buffer_one_free;
    end

    always @*
    begin
        mode_nxt = mode_r;
        rtr_nxt = rtr_r;
        hit_nxt = hit_r;
        rdata_nxt = reg_rdata;

        if (wr_hit)
        begin
            mode_nxt = reg_wdata[`RBCTL_MODE_HI:`RBCTL_MODE_LO];
        end

        // The read value is captured once and held until the next read.
        if (reg_rd)
        begin
            if (sel)
            begin
                rdata_nxt = status;
            end
            else
            begin
                rdata_nxt = 8'h00;
            end
        end

        if (route_one)
        begin
            rtr_nxt = msg_remote;
            hit_nxt = msg_filter_index;
        end

        // Both load strobes are registered, so each lags route_one by one cycle.
        load_one_nxt = route_one;
        load_roll_nxt = route_one & from_zero;
    end

    // Register fields.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_r <= `RBCTL_MODE_RESET;
            rtr_r <= `RBCTL_RTR_RESET;
            hit_r <= `RBCTL_HIT_RESET;
        end
        else
        begin
            mode_r <= mode_nxt;
            rtr_r <= rtr_nxt;
            hit_r <= hit_nxt;
        end
    end

    // Read data port.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= `RBCTL_RESET;
        end
        else
        begin
            reg_rdata <= rdata_nxt;
        end
    end

    // Load strobes towards the message store.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_buffer_one <= 1'b0;
            load_rollover <= 1'b0;
        end
        else
        begin
            load_buffer_one <= load_one_nxt;
            load_rollover <= load_roll_nxt;
        end
    end

    // The message store itself lies outside this block.
    // This block only decides whether buffer one takes the message.
    // Its status fields then describe the message that was taken.
    // A message that is refused leaves every field untouched.
    // The host sees the result on its next read of the register.
endmodule // rbctl_buffer_one_control

// ===== test/rbctl_host_model.sv
`timescale 1ns/1ps
module rbctl_host_model(input wire clk, output reg [7:0] reg_addr,
output reg reg_wr, output reg reg_rd, output reg [7:0] reg_wdata);
initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 18'h0;
task acc(input w, input [7:0] a, d);
@(posedge clk);
{reg_addr, reg_wr, reg_rd, reg_wdata} <= {a, w, !w, d};
@(posedge clk);
{reg_wr, reg_rd} <= 2'h0;
endtask
endmodule // rbctl_host_model

// ===== test/rbctl_properties.sv
`timescale 1ns/1ps
module rbctl_properties(input wire clk, input wire rst_n,
input wire [7:0] reg_addr, input wire reg_rd, input wire [7:0] reg_rdata,
input wire msg_valid, input wire rollover_enable, input wire buffer_zero_full,
input wire buffer_one_free, input wire load_buffer_one, input wire load_rollover);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
sequence s_no_roll; msg_valid && !(rollover_enable && buffer_zero_full);
endsequence
sequence s_idle; !msg_valid; endsequence
chk_unimpl_zero: assert property (
reg_rdata[7] == 1'b0 && reg_rdata[4] == 1'b0) else $error("spare bit set");
chk_other_addr: assert property (
reg_rd && reg_addr != 8'h70 |=> reg_rdata == 8'h00) else $error("stray data");
chk_roll_cause: assert property (
load_rollover |-> $past(msg_valid && rollover_enable && buffer_zero_full))
else $error("bad rollover");
chk_roll_block: assert property (
s_no_roll |=> !load_rollover) else $error("rollover without cause");
chk_roll_subset: assert property (
load_rollover |-> load_buffer_one) else $error("rollover not loaded");
chk_idle_quiet: assert property (
s_idle |=> !load_buffer_one) else $error("load without message");
chk_no_room: assert property (
msg_valid && !buffer_one_free |=> !load_buffer_one) else $error("no room");
endmodule // rbctl_properties
bind rbctl_buffer_one_control rbctl_properties chk_u(.*);

// ===== test/receive_buffer_one_control_tb_top.sv
`timescale 1ns/1ps
module receive_buffer_one_control_tb_top;
reg clk = 0, rst_n = 0, msg_valid = 0, msg_extended = 0, msg_remote = 0;
reg msg_filter_hit = 0, rollover_enable = 0, buffer_zero_full = 0;
reg buffer_one_free = 1, rd_d = 0;
reg [2:0] msg_filter_index = 0;
reg [2:0] exp_hit = 0;
reg exp_rtr = 0;
reg [31:0] rnd = 0;
integer k;
reg [7:0] exp_q[$];
wire [7:0] reg_addr, reg_wdata, reg_rdata;
wire reg_wr, reg_rd, load_buffer_one, load_rollover;
integer err_count = 0, compares = 0, seed = 99;
rbctl_host_model host_u(.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
.reg_rd(reg_rd), .reg_wdata(reg_wdata));
rbctl_buffer_one_control dut_u(.*);
initial forever #2 clk = ~clk;
task give_verdict;
$display("errors=%0d compares=%0d", err_count, compares);
if (err_count == 0 && compares > 0)
    $display("Test passed");
else
    $display("Test failed");
$finish;
endtask
task rd(input [7:0] a, e);
exp_q.push_back(e);
host_u.acc(1'b0, a, 8'h00);
endtask
task msg(input r, input [2:0] i, input ro, input x, input h);
@(posedge clk);
{msg_valid, msg_remote, msg_filter_index} <= {1'b1, r, i};
{rollover_enable, buffer_zero_full, msg_filter_hit, msg_extended} <=
    {ro, ro, h, x};
@(posedge clk);
msg_valid <= 1'b0;
endtask
always @(posedge clk)
begin
    rd_d <= reg_rd;
    if (rd_d)
    begin
        compares = compares + 1;
        if (reg_rdata !== exp_q[0])
        begin
            err_count = err_count + 1;
            $display("[FAIL] %0t %h %h", $time, reg_rdata, exp_q[0]);
        end
        void'(exp_q.pop_front());
    end
end
initial
begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h70, 8'h00);
    host_u.acc(1'b1, 8'h70, 8'hff);
    host_u.acc(1'b1, 8'h71, 8'h00);
    rd(8'h70, 8'h60);
    rd(8'h71, 8'h00);
    msg(1'b1, 3'h5, 1'b0, 1'b0, 1'b0);
    rd(8'h70, 8'h6d);
    msg(1'b0, 3'h1, 1'b1, 1'b0, 1'b0);
    rd(8'h70, 8'h61);
    msg(1'b1, 3'h0, 1'b0, 1'b0, 1'b1);
    rd(8'h70, 8'h61);
    host_u.acc(1'b1, 8'h70, 8'h40);
    msg(1'b1, 3'h4, 1'b0, 1'b0, 1'b1);
    rd(8'h70, 8'h41);
    msg(1'b1, 3'h4, 1'b0, 1'b1, 1'b1);
    rd(8'h70, 8'h4c);
    host_u.acc(1'b1, 8'h70, 8'h20);
    exp_rtr = 1'b1;
    exp_hit = 3'h4;
    for (k = 0; k < 8; k = k + 1)
    begin
        rnd = $random(seed);
        msg(rnd[0], {2'h2, rnd[1]}, 1'b0, rnd[2], rnd[3]);
        if (rnd[3] && !rnd[2])
        begin
            exp_rtr = rnd[0];
            exp_hit = {2'h2, rnd[1]};
        end
        rd(8'h70, {3'h1, 1'b0, exp_rtr, exp_hit});
    end
    host_u.acc(1'b1, 8'h70, 8'h00);
    msg(1'b0, 3'h5, 1'b0, 1'b1, 1'b1);
    rd(8'h70, 8'h05);
    msg(1'b1, 3'h4, 1'b0, 1'b0, 1'b0);
    rd(8'h70, 8'h05);
    buffer_one_free <= 1'b0;
    msg(1'b1, 3'h4, 1'b0, 1'b1, 1'b1);
    rd(8'h70, 8'h05);
    buffer_one_free <= 1'b1;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h70, 8'h00);
    repeat (3) @(posedge clk);
    give_verdict;
end
initial
begin
    #20000;
    err_count = err_count + 1;
    give_verdict;
end
endmodule // receive_buffer_one_control_tb_top
